// ### core/smbioe_ctrl.sv
// Register front end and sequencer for the SMBus expander master
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ns

// Behaviour
// R1: Done flag bit 31, reset zero, write-one-clear
// R2: Done set when selected refresh completes
// R3: Done set when test-mode update completes
// R4: Done set when selected expander init completes
// R5: Low register holds expander 0..3 addresses
// R6: High register holds expander 4 address
// R7: Addresses reset zero, sticky, used as targets
// R8: Select field picks expander, 5+ reserved
// R9: Reload starts refresh, or update in test mode, always reads zero
// R10: Test mode drives written data, not core; init requests still carry i_core_out
// R11: Unselected expander completions never set done
module smbioe_ctrl
  import smbioe_pkg::*;
#(
  parameter int NEXP = SMBIOE_NEXP       // Number of expanders
) (
  input  wire logic        i_clk_sys,    // System clock
  input  wire logic        i_nrst,       // Async reset, low
  input  wire logic [11:0] i_addr,       // Register byte address
  input  wire logic [31:0] i_wdata,      // Write data
  input  wire logic        i_wr,         // Write strobe
  input  wire logic        i_rd,         // Read strobe
  output logic      [31:0] o_rdata,      // Read data, next cycle
  input  wire logic [15:0] i_core_out,   // Outputs from core logic
  input  smbioe_cpl_t      i_cpl,        // Engine completion
  output smbioe_req_t      o_req,        // Engine request
  output logic             o_irq         // Level interrupt
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [NEXP-1:0][SMBIOE_AW-1:0] tgt;   // Target addresses
    logic [NEXP-1:0][SMBIOE_DW-1:0] pins;  // Pin value images
    logic                 tmode;     // Test mode
    logic [3:0]           sel;       // Selected expander
    logic                 done;      // Operation complete flag
    logic                 rl_pend;   // Reload waiting to issue
    smbioe_op_t           rl_op;     // Kind of pending reload
    logic [NEXP-1:0]      init_pend; // Inits waiting to issue
    smbioe_fsm_t          fsm;       // Sequencer state
    smbioe_op_t           cur_op;    // Operation in flight
    logic [2:0]           cur_idx;   // Expander in flight
    logic [2:0]           irq_st;    // Sticky event status
    logic [2:0]           irq_en;    // Event enables
    logic [31:0]          rdata;     // Read data register
    smbioe_req_t          req;       // Request register
    logic                 irq;       // Interrupt register
  } smbioe_state_t;

  smbioe_state_t st_r;               // Registered state
  smbioe_state_t st_nxt;             // Next state

  // ----------------------------------------------------------------
  // Decode helpers
  // ----------------------------------------------------------------
  logic [2:0]   sel_idx;             // Select as an index
  logic         sel_ok;              // Select names an expander
  logic [2:0]   evt;                 // Events this cycle
  logic [31:0]  ctrl_rd;             // Control read image
  logic [31:0]  lo_rd;               // Low address read image
  logic [31:0]  hi_rd;               // High address read image

  // Select decode; reserved codes match nothing
  always_comb begin
    sel_idx = st_r.sel[2:0];
    sel_ok  = (st_r.sel <= SMBIOE_SEL_MAX); // [R8]
  end

  // Completion events for the selected expander only
  always_comb begin
    evt = 3'h0;
    if (i_cpl.valid && st_r.fsm == SMBIOE_BUSY && sel_ok &&
        i_cpl.idx == sel_idx && i_cpl.idx == st_r.cur_idx) begin // [R11]
      case (i_cpl.op)
        SMBIOE_OP_REFRESH: evt[SMBIOE_IRQ_REFRESH] = 1'b1; // [R2]
        SMBIOE_OP_UPDATE:  evt[SMBIOE_IRQ_UPDATE]  = 1'b1; // [R3]
        SMBIOE_OP_INIT:    evt[SMBIOE_IRQ_INIT]    = 1'b1; // [R4]
        default:           evt = 3'h0;
      endcase
    end
  end

  // Read images; reserved bits read as zero
  always_comb begin
    ctrl_rd = 32'h0000_0000;
    if (sel_ok) begin
      ctrl_rd[SMBIOE_DATA_LSB +: SMBIOE_DW] = st_r.pins[sel_idx];
    end
    ctrl_rd[SMBIOE_RELOAD_BIT]          = 1'b0;      // [R9]
    ctrl_rd[SMBIOE_TM_BIT]              = st_r.tmode;
    ctrl_rd[SMBIOE_SEL_LSB +: 4]        = st_r.sel;
    ctrl_rd[SMBIOE_DONE_BIT]            = st_r.done; // [R1]
    lo_rd = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      lo_rd[i*SMBIOE_LANE_W + SMBIOE_ADDR_LSB +: SMBIOE_AW] =
        st_r.tgt[i];                                 // [R5]
    end
    hi_rd = 32'h0000_0000;
    hi_rd[SMBIOE_ADDR_LSB +: SMBIOE_AW] = st_r.tgt[4]; // [R6]
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt           = st_r;
    st_nxt.req.valid = 1'b0;
    st_nxt.rdata     = 32'h0000_0000;

    // Register writes
    if (i_wr) begin
      if (i_addr == SMBIOE_OFS_CTRL) begin
        st_nxt.tmode = i_wdata[SMBIOE_TM_BIT];
        st_nxt.sel   = i_wdata[SMBIOE_SEL_LSB +: 4];   // [R8]
        if (i_wdata[SMBIOE_DONE_BIT]) begin
          st_nxt.done = 1'b0;                          // [R1]
        end
        // Data is only writable in test mode, for the selection
        if (i_wdata[SMBIOE_TM_BIT] &&
            i_wdata[SMBIOE_SEL_LSB +: 4] <= SMBIOE_SEL_MAX) begin
          st_nxt.pins[i_wdata[SMBIOE_SEL_LSB +: 3]] =
            i_wdata[SMBIOE_DATA_LSB +: SMBIOE_DW];     // [R10]
        end
        if (i_wdata[SMBIOE_RELOAD_BIT]) begin
          st_nxt.rl_pend = 1'b1;                       // [R9]
          st_nxt.rl_op   = i_wdata[SMBIOE_TM_BIT] ?
                           SMBIOE_OP_UPDATE : SMBIOE_OP_REFRESH; // [R3]
        end
      end else if (i_addr == SMBIOE_OFS_ADDR_LO) begin
        for (int i = 0; i < 4; i++) begin
          st_nxt.tgt[i] =
            i_wdata[i*SMBIOE_LANE_W + SMBIOE_ADDR_LSB +: SMBIOE_AW];
        end
        st_nxt.init_pend[3:0] = 4'hF;                  // [R4]
      end else if (i_addr == SMBIOE_OFS_ADDR_HI) begin
        st_nxt.tgt[4]       = i_wdata[SMBIOE_ADDR_LSB +: SMBIOE_AW];
        st_nxt.init_pend[4] = 1'b1;                    // [R4]
      end else if (i_addr == SMBIOE_OFS_IRQ_CLR) begin
        st_nxt.irq_st = st_r.irq_st & ~i_wdata[2:0];
      end else if (i_addr == SMBIOE_OFS_IRQ_EN) begin
        st_nxt.irq_en = i_wdata[2:0];
      end
    end

    // Register reads; unmapped addresses return zero
    if (i_rd) begin
      if (i_addr == SMBIOE_OFS_CTRL) begin
        st_nxt.rdata = ctrl_rd;
      end else if (i_addr == SMBIOE_OFS_ADDR_LO) begin
        st_nxt.rdata = lo_rd;
      end else if (i_addr == SMBIOE_OFS_ADDR_HI) begin
        st_nxt.rdata = hi_rd;
      end else if (i_addr == SMBIOE_OFS_IRQ_ST) begin
        st_nxt.rdata = {29'h0000_0000, st_r.irq_st};
      end else if (i_addr == SMBIOE_OFS_IRQ_EN) begin
        st_nxt.rdata = {29'h0000_0000, st_r.irq_en};
      end
    end

    // Sequencer: one transaction in flight at a time
    case (st_r.fsm)
      SMBIOE_IDLE: begin
        if (st_r.rl_pend) begin
          st_nxt.rl_pend = 1'b0;
          if (sel_ok) begin
            st_nxt.req.valid = 1'b1;                   // [R9]
            st_nxt.req.op    = st_r.rl_op;
            st_nxt.req.idx   = sel_idx;
            st_nxt.req.addr  = st_r.tgt[sel_idx];      // [R7]
            st_nxt.req.wdata = st_r.tmode ?
                               st_r.pins[sel_idx] : i_core_out; // [R10]
            st_nxt.cur_op    = st_r.rl_op;
            st_nxt.cur_idx   = sel_idx;
            st_nxt.fsm       = SMBIOE_BUSY;
          end
        end else if (|st_r.init_pend) begin
          for (int i = NEXP - 1; i >= 0; i--) begin
            if (st_r.init_pend[i]) begin
              st_nxt.req.idx  = 3'(i);
              st_nxt.req.addr = st_r.tgt[i];           // [R7]
              st_nxt.cur_idx  = 3'(i);
            end
          end
          st_nxt.init_pend[st_nxt.cur_idx] = 1'b0;
          st_nxt.req.valid = 1'b1;
          st_nxt.req.op    = SMBIOE_OP_INIT;
          st_nxt.req.wdata = i_core_out;
          st_nxt.cur_op    = SMBIOE_OP_INIT;
          st_nxt.fsm       = SMBIOE_BUSY;
        end
      end
      SMBIOE_BUSY: begin
        if (i_cpl.valid && i_cpl.idx == st_r.cur_idx) begin
          if (st_r.cur_op != SMBIOE_OP_INIT) begin
            st_nxt.pins[st_r.cur_idx] = i_cpl.rdata;
          end
          st_nxt.fsm = SMBIOE_IDLE;
        end
      end
      default: st_nxt.fsm = SMBIOE_IDLE;
    endcase

    // Completion sets win over a same-cycle software clear
    if (|evt) begin
      st_nxt.done = 1'b1;                              // [R2]
    end
    st_nxt.irq_st = st_nxt.irq_st | evt;
    st_nxt.irq    = |(st_nxt.irq_st & st_r.irq_en);
  end

  // ----------------------------------------------------------------
  // State register; addresses reset to zero and hold otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r.tgt       <= '{default: SMBIOE_ADDR_RST};   // [R7]
      st_r.pins      <= '{default: SMBIOE_DATA_RST};
      st_r.tmode     <= 1'b0;
      st_r.sel       <= 4'h0;
      st_r.done      <= 1'b0;                          // [R1]
      st_r.rl_pend   <= 1'b0;
      st_r.rl_op     <= SMBIOE_OP_REFRESH;
      st_r.init_pend <= '0;
      st_r.fsm       <= SMBIOE_IDLE;
      st_r.cur_op    <= SMBIOE_OP_REFRESH;
      st_r.cur_idx   <= 3'h0;
      st_r.irq_st    <= SMBIOE_IRQ_RST;
      st_r.irq_en    <= SMBIOE_IRQ_RST;
      st_r.rdata     <= 32'h0000_0000;
      st_r.req       <= '0;
      st_r.irq       <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs straight from the state register
  // ----------------------------------------------------------------
  assign o_rdata = st_r.rdata;
  assign o_req   = st_r.req;
  assign o_irq   = st_r.irq;

endmodule : smbioe_ctrl

// ### include/smbioe_pkg.sv
// Constants and types for the SMBus expander master control block
package smbioe_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] SMBIOE_OFS_CTRL    = 12'h430; // Control
  localparam logic [11:0] SMBIOE_OFS_ADDR_LO = 12'h434; // Addr 0..3
  localparam logic [11:0] SMBIOE_OFS_ADDR_HI = 12'h438; // Addr 4
  localparam logic [11:0] SMBIOE_OFS_IRQ_ST  = 12'h43C; // Irq status
  localparam logic [11:0] SMBIOE_OFS_IRQ_CLR = 12'h440; // Irq clear
  localparam logic [11:0] SMBIOE_OFS_IRQ_EN  = 12'h444; // Irq enable

  // ----------------------------------------------------------------
  // Control register field positions
  // ----------------------------------------------------------------
  localparam int SMBIOE_DATA_LSB   = 0;  // Pin values 15:0
  localparam int SMBIOE_RELOAD_BIT = 24; // Reload request
  localparam int SMBIOE_TM_BIT     = 25; // Test mode
  localparam int SMBIOE_SEL_LSB    = 26; // Select 29:26
  localparam int SMBIOE_DONE_BIT   = 31; // Operation complete

  // Address field: 7 bits at bit 1 of each byte lane
  localparam int SMBIOE_ADDR_LSB   = 1;
  localparam int SMBIOE_LANE_W     = 8;

  // ----------------------------------------------------------------
  // Sizes and reset values
  // ----------------------------------------------------------------
  localparam int          SMBIOE_NEXP      = 5;     // Expanders
  localparam int          SMBIOE_AW        = 7;     // Target addr
  localparam int          SMBIOE_DW        = 16;    // Pin values
  localparam logic [3:0]  SMBIOE_SEL_MAX   = 4'h4;  // Last legal sel
  localparam logic [6:0]  SMBIOE_ADDR_RST  = 7'h00; // Addr reset
  localparam logic [15:0] SMBIOE_DATA_RST  = 16'h0000;
  localparam logic [2:0]  SMBIOE_IRQ_RST   = 3'h0;

  // Interrupt status bit positions
  localparam int SMBIOE_IRQ_REFRESH = 0; // Refresh finished
  localparam int SMBIOE_IRQ_UPDATE  = 1; // Test update finished
  localparam int SMBIOE_IRQ_INIT    = 2; // Initialisation finished

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SMBIOE_OP_REFRESH,                // Refresh inputs and outputs
    SMBIOE_OP_UPDATE,                 // Test-mode output update
    SMBIOE_OP_INIT                    // Initialisation sequence
  } smbioe_op_t;

  typedef enum logic {
    SMBIOE_IDLE,
    SMBIOE_BUSY
  } smbioe_fsm_t;

  // Transaction request toward the SMBus master engine
  typedef struct packed {
    logic                    valid;   // One-cycle request pulse
    smbioe_op_t              op;      // Kind of transaction
    logic [2:0]              idx;     // Expander number
    logic [SMBIOE_AW-1:0]    addr;    // Target SMBus address
    logic [SMBIOE_DW-1:0]    wdata;   // Output values to drive
  } smbioe_req_t;

  // Completion report from the SMBus master engine
  typedef struct packed {
    logic                    valid;   // One-cycle completion pulse
    smbioe_op_t              op;      // Kind that finished
    logic [2:0]              idx;     // Expander number
    logic [SMBIOE_DW-1:0]    rdata;   // Pin values read back
  } smbioe_cpl_t;

endpackage : smbioe_pkg

// ### verification/smbioe_ctrl_chk.sv
// Assertion checker for the SMBus expander master control block
`timescale 1ns/1ns
module smbioe_ctrl_chk
  import smbioe_pkg::*;
#(
  parameter int NEXP = SMBIOE_NEXP      // Expanders
) (
  input wire logic        i_clk_sys,    // Clock
  input wire logic        i_nrst,       // Reset, low
  input wire logic [11:0] i_addr,       // Address
  input wire logic [31:0] i_wdata,      // Write data
  input wire logic        i_wr,         // Write strobe
  input wire logic        i_rd,         // Read strobe
  input wire logic [31:0] o_rdata,      // Read data
  input wire logic [15:0] i_core_out,   // Core outputs
  input smbioe_cpl_t      i_cpl,        // Completion
  input smbioe_req_t      o_req,        // Request
  input wire logic        o_irq         // Interrupt
);
  // ----------------------------------------
  // Outstanding request tracker
  // ----------------------------------------
  logic busy_r;                         // Request out, not answered
  logic idle;                           // Nothing in flight
  assign idle = !busy_r && !o_req.valid;
  // Set on issue, cleared by the matching completion
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      busy_r <= 1'b0;
    end else if (o_req.valid) begin
      busy_r <= 1'b1;
    end else if (i_cpl.valid && i_cpl.idx == o_req.idx) begin
      busy_r <= 1'b0;
    end
  end
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  sequence s_rd(a);
    i_rd && i_addr == a;
  endsequence
  sequence s_reload;
    i_wr && i_addr == SMBIOE_OFS_CTRL && i_wdata[SMBIOE_RELOAD_BIT];
  endsequence
  property p_rd_idle;
    !i_rd |=> o_rdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_lo_rsv;
    s_rd(SMBIOE_OFS_ADDR_LO) |=> (o_rdata & 32'h01010101) == 32'h0;
  endproperty
  a_lo_rsv: assert property (p_lo_rsv)
    else $error("low address reserved bits set");
  property p_hi_rsv;
    s_rd(SMBIOE_OFS_ADDR_HI) |=> o_rdata[31:8] == 24'h0 && !o_rdata[0];
  endproperty
  a_hi_rsv: assert property (p_hi_rsv)
    else $error("high address reserved bits set");
  property p_ctrl_rz;
    s_rd(SMBIOE_OFS_CTRL) |=> !o_rdata[24] && !o_rdata[30];
  endproperty
  a_ctrl_rz: assert property (p_ctrl_rz)
    else $error("reload or reserved bit reads one");
  property p_req_pulse;
    o_req.valid |=> !o_req.valid;
  endproperty
  a_req_pulse: assert property (p_req_pulse)
    else $error("request longer than one cycle");
  // Reload is latched at the write edge and issued one edge later
  property p_reload;
    s_reload ##0 (idle && i_wdata[29:26] < NEXP) ##1 idle |=>
      o_req.valid && o_req.idx == $past(i_wdata[28:26], 2) &&
      o_req.op == ($past(i_wdata[25], 2) ? SMBIOE_OP_UPDATE :
      SMBIOE_OP_REFRESH);
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload did not issue the right request");
  property p_hold;
    !o_req.valid |-> $stable({o_req.op, o_req.idx, o_req.addr});
  endproperty
  a_hold: assert property (p_hold)
    else $error("request fields moved while idle");
  property p_irq_rise;
    $rose(o_irq) |-> $past(i_cpl.valid) || $past(i_cpl.valid, 2) ||
      $past(i_wr) || $past(i_wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt rose without cause");
  property p_irq_fall;
    $fell(o_irq) |-> $past(i_wr) || $past(i_wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt fell without a write");
endmodule : smbioe_ctrl_chk

bind smbioe_ctrl smbioe_ctrl_chk #(.NEXP(NEXP)) u_chk (
  .i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_core_out(i_core_out), .i_cpl(i_cpl), .o_req(o_req), .o_irq(o_irq));

// ### verification/smbioe_ctrl_tb.sv
// Self-checking bench for the SMBus expander master control block
`timescale 1ns/1ns
module smbioe_ctrl_tb
  import smbioe_pkg::*;
;
  logic i_clk_sys = 1'b0;
  logic i_nrst, i_wr, i_rd, o_irq, stray;
  logic [11:0] i_addr;
  logic [31:0] i_wdata, o_rdata, v;
  logic [15:0] i_core_out;
  logic [7:0] dly;
  logic [3:0] s;
  smbioe_cpl_t i_cpl;
  smbioe_req_t o_req, r;
  smbioe_req_t seen[$];                 // Requests seen on the link
  logic [6:0] tgt [5] = '{7'h78, 7'h56, 7'h34, 7'h12, 7'h1A};
  logic [11:0] ofs [6] = '{12'h430, 12'h434, 12'h438, 12'h43C,
                           12'h444, 12'h448};
  int n_errors = 0, checks_done = 0, cyc = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  smbioe_ctrl dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_core_out(i_core_out), .i_cpl(i_cpl),
    .o_req(o_req), .o_irq(o_irq));
  smbioe_engine_model eng (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst),
    .i_req(o_req), .i_dly(dly), .i_stray(stray), .o_cpl(i_cpl));
  // Log requests and cut a hang short
  always @(posedge i_clk_sys) begin
    if (o_req.valid === 1'b1) seen.push_back(o_req);
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_clk_sys);
    i_addr  <= a;
    i_wdata <= d;
    i_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge i_clk_sys);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_rd <= 1'b0;
    #1 v = o_rdata;
  endtask : rd
  // Take the next request and compare it, wdata under mask m
  task automatic exp_req(input smbioe_op_t op, input logic [2:0] ix,
                         input logic [15:0] wd, input logic [15:0] m);
    int t;
    for (t = 0; t < 100 && seen.size() == 0; t++) @(posedge i_clk_sys);
    if (seen.size() == 0) seen.push_back('0);
    r = seen.pop_front();
    chk({4'h0, r.op, r.idx, r.addr, r.wdata & m},
        {4'h0, op, ix, tgt[ix], wd & m});
  endtask : exp_req
  task automatic wait_cpl();
    int t;
    for (t = 0; t < 100; t++) begin
      @(posedge i_clk_sys);
      #1 if (i_cpl.valid === 1'b1 && i_cpl.idx === o_req.idx) break;
    end
    repeat (3) @(posedge i_clk_sys);
  endtask : wait_cpl
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  initial begin
    {i_nrst, i_wr, i_rd, stray, i_addr, i_wdata} = '0;
    i_core_out = 16'h1234;
    dly = 8'h02;
    repeat (3) @(posedge i_clk_sys);
    i_nrst <= 1'b1;
    wr(12'h448, 32'hFFFFFFFF);
    foreach (ofs[k]) begin
      rd(ofs[k]);
      chk(v, 32'h0);
    end
    $display("test reset values done");
    wr(SMBIOE_OFS_ADDR_LO, 32'h2569ADF1);
    rd(SMBIOE_OFS_ADDR_LO);
    chk(v, 32'h2468ACF0);
    for (int k = 0; k < 4; k++) begin
      exp_req(SMBIOE_OP_INIT, k[2:0], 16'h0, 16'h0);
      wait_cpl();
    end
    rd(SMBIOE_OFS_CTRL);
    chk(v & 32'h80000000, 32'h80000000);
    wr(SMBIOE_OFS_CTRL, 32'h80000000);
    rd(SMBIOE_OFS_CTRL);
    chk(v, 32'h0);
    wr(SMBIOE_OFS_ADDR_HI, 32'hFFFFFF35);
    rd(SMBIOE_OFS_ADDR_HI);
    chk(v, 32'h00000034);
    exp_req(SMBIOE_OP_INIT, 3'h4, 16'h0, 16'h0);
    wait_cpl();
    rd(SMBIOE_OFS_CTRL);
    chk(v, 32'h0);
    rd(SMBIOE_OFS_IRQ_ST);
    chk(v, 32'h4);
    wr(SMBIOE_OFS_IRQ_CLR, 32'h7);
    $display("test addresses done");
    wr(SMBIOE_OFS_IRQ_EN, 32'h1);
    for (int k = 0; k < 5; k++) begin
      s = k[3:0];
      dly = 8'(k * 3 + 1);
      stray = (k == 2);
      wr(SMBIOE_OFS_CTRL, {2'b00, s, 2'b01, 24'h0});
      exp_req(SMBIOE_OP_REFRESH, s[2:0], 16'h1234, 16'hFFFF);
      wait_cpl();
      rd(SMBIOE_OFS_CTRL);
      chk(v, {2'b10, s, 10'h0, tgt[k], 6'h00, s[2:0]});
      chk({31'h0, o_irq}, 32'h1);
      wr(SMBIOE_OFS_CTRL, {2'b10, s, 26'h0});
      wr(SMBIOE_OFS_IRQ_CLR, 32'h1);
      repeat (3) @(posedge i_clk_sys);
      chk({31'h0, o_irq}, 32'h0);
    end
    stray = 1'b0;
    wr(SMBIOE_OFS_CTRL, 32'h15000000);
    repeat (10) @(posedge i_clk_sys);
    chk(seen.size(), 32'h0);
    $display("test refresh done");
    wr(SMBIOE_OFS_IRQ_EN, 32'h0);
    wr(SMBIOE_OFS_CTRL, 32'h0600C35A);
    wr(SMBIOE_OFS_CTRL, 32'h0700C35A);
    exp_req(SMBIOE_OP_UPDATE, 3'h1, 16'hC35A, 16'hFFFF);
    wait_cpl();
    rd(SMBIOE_OFS_CTRL);
    chk(v, 32'h8600C35A);
    rd(SMBIOE_OFS_IRQ_ST);
    chk(v, 32'h2);
    chk({31'h0, o_irq}, 32'h0);
    wr(SMBIOE_OFS_IRQ_EN, 32'h2);
    repeat (3) @(posedge i_clk_sys);
    chk({31'h0, o_irq}, 32'h1);
    $display("test test mode done");
    print_verdict();
  end
endmodule : smbioe_ctrl_tb

// ### verification/smbioe_engine_model.sv
// Behavioural SMBus expander engine answering the control block
`timescale 1ns/1ns
module smbioe_engine_model
  import smbioe_pkg::*;
(
  input  wire logic       i_clk_sys,    // Clock
  input  wire logic       i_nrst,       // Reset, low
  input  smbioe_req_t     i_req,        // Request from block
  input  wire logic [7:0] i_dly,        // Answer delay, cycles
  input  wire logic       i_stray,      // Answer wrong expander first
  output smbioe_cpl_t     o_cpl         // Completion to block
);
  smbioe_req_t req_r;                   // Transaction in flight
  logic [7:0]  cnt_r;                   // Cycles left
  logic        act_r;                   // Transaction running
  // Count down then report; idle data toggles so nothing stale lingers
  always_ff @(posedge i_clk_sys or negedge i_nrst) begin
    if (!i_nrst) begin
      act_r <= 1'b0;
      cnt_r <= 8'h00;
      req_r <= '0;
      o_cpl <= '0;
    end else begin
      o_cpl.valid <= 1'b0;
      o_cpl.rdata <= ~o_cpl.rdata;
      if (i_req.valid) begin
        act_r <= 1'b1;
        cnt_r <= i_dly;
        req_r <= i_req;
      end else if (act_r && cnt_r != 8'h00) begin
        cnt_r <= cnt_r - 8'h01;
        if (i_stray && cnt_r == 8'h01) begin
          o_cpl.valid <= 1'b1;
          o_cpl.idx   <= req_r.idx ^ 3'h1;
        end
      end else if (act_r) begin
        act_r       <= 1'b0;
        o_cpl.valid <= 1'b1;
        o_cpl.op    <= req_r.op;
        o_cpl.idx   <= req_r.idx;
        o_cpl.rdata <= (req_r.op == SMBIOE_OP_UPDATE) ? req_r.wdata :
                       {req_r.addr, 6'h00, req_r.idx};
      end
    end
  end
endmodule : smbioe_engine_model
